// File: sim/swt_watchdog_props.sv
`timescale 1ns/1ns
module swt_watchdog_props
    import swt_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [swt_pkg::ADDR_WIDTH-1:0] i_addr,
    input wire logic [swt_pkg::DATA_WIDTH-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [swt_pkg::DATA_WIDTH-1:0] o_rdata,
    input wire logic o_wdt_irq,
    input wire logic o_sys_reset,
    input wire logic o_irq
);
    localparam int FIRST_RESET = (1 << TAP_CODE0) + RESET_DELAY_CLOCKS;
    localparam int EARLIEST = (1 << TAP_CODE0) - 8;
    logic [26:0] since_reg;
    logic [26:0] since_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [1:0] en_reg;
    logic [1:0] en_next;
    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    // Shadows of what software wrote; cycles counted since the last restart
    always_comb
    begin
        since_next = (since_reg == '1) ? since_reg : since_reg + 27'h1;
        ctrl_next = ctrl_reg;
        en_next = en_reg;
        sel_next = sel_reg;
        if (i_write && i_addr == WATCHDOG_CONTROL_OFFSET)
        begin
            ctrl_next = i_wdata;
            if (i_wdata[RESTART_BIT])
                since_next = '0;
        end
        if (i_write && i_addr == IRQ_ENABLE_OFFSET)
            en_next = i_wdata[1:0];
        if (i_write && i_addr == CLOCK_CONTROL_OFFSET)
            sel_next = i_wdata[7:6];
    end
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            since_reg <= '0;
            ctrl_reg <= 8'h00;
            en_reg <= 2'h0;
            sel_reg <= 2'h0;
        end
        else
        begin
            since_reg <= since_next;
            ctrl_reg <= ctrl_next;
            en_reg <= en_next;
            sel_reg <= sel_next;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    property p_rst_hold;
        $rose(o_sys_reset) |-> o_sys_reset [*8] ##1 !o_sys_reset;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset pulse length wrong");
    property p_rst_needs_enable;
        $rose(o_sys_reset) |-> ctrl_reg[RESET_ENABLE_BIT];
    endproperty
    a_rst_needs_enable: assert property (p_rst_needs_enable) else $error("reset while disabled");
    property p_rst_window;
        $rose(o_sys_reset) && sel_reg == 2'h0 |-> since_reg >= FIRST_RESET && since_reg <= FIRST_RESET + 8;
    endproperty
    a_rst_window: assert property (p_rst_window) else $error("reset off its interval");
    property p_restart_reads_zero;
        $past(i_read) && $past(i_addr) == WATCHDOG_CONTROL_OFFSET |-> !o_rdata[RESTART_BIT];
    endproperty
    a_restart_reads_zero: assert property (p_restart_reads_zero) else $error("restart bit stuck");
    property p_wdt_irq_enables;
        o_wdt_irq |-> ctrl_reg[WDT_IRQ_ENABLE_BIT] && ctrl_reg[GLOBAL_IRQ_ENABLE_BIT];
    endproperty
    a_wdt_irq_enables: assert property (p_wdt_irq_enables) else $error("irq without enables");
    property p_no_early_irq;
        o_wdt_irq && sel_reg == 2'h0 |-> since_reg >= EARLIEST;
    endproperty
    a_no_early_irq: assert property (p_no_early_irq) else $error("time-out too early");
    property p_event_irq_enable;
        o_irq |-> en_reg != 2'h0;
    endproperty
    a_event_irq_enable: assert property (p_event_irq_enable) else $error("event irq while masked");
    property p_reset_event;
        $rose(o_sys_reset) && en_reg[EVT_WDT_RESET_BIT] |-> ##[1:2] o_irq;
    endproperty
    a_reset_event: assert property (p_reset_event) else $error("reset event missing");
endmodule : swt_watchdog_props
bind swt_watchdog swt_watchdog_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_wdt_irq(o_wdt_irq),
    .o_sys_reset(o_sys_reset), .o_irq(o_irq));

// File: sim/test_system_watchdog_timer.sv
`timescale 1ns/1ns
module test_system_watchdog_timer;
    import swt_pkg::*;
    typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} swt_row_t;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic [7:0] o_rdata;
    logic o_wdt_irq;
    logic o_sys_reset;
    logic o_irq;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0;
    int n;
    swt_row_t rows [10] = '{'{4'h0, 8'hC0, 8'hC0}, '{4'h0, 8'h40, 8'h40}, '{4'h0, 8'h80, 8'h80},
        '{4'h0, 8'h00, 8'h00}, '{4'h1, 8'h92, 8'h92}, '{4'h1, 8'h91, 8'h90}, '{4'h2, 8'h03, 8'h03},
        '{4'h3, 8'hFF, 8'h00}, '{4'h4, 8'hFF, 8'h00}, '{4'hF, 8'h5A, 8'h00}};
    swt_watchdog uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_wdt_irq(o_wdt_irq),
        .o_sys_reset(o_sys_reset), .o_irq(o_irq));
    always #2 i_clock = ~i_clock;
    always @(posedge i_clock) cyc <= cyc + 1;
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Strobes drop one edge before the next task raises them again
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
        @(posedge i_clock);
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string name);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        @(negedge i_clock);
        check(name, o_rdata, e);
        @(posedge i_clock);
    endtask : rdc
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        for (int i = 0; i < 10; i++)
        begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e, "register row");
        end
        wr(WATCHDOG_CONTROL_OFFSET, 8'h93);
        t0 = cyc;
        for (n = 0; n < 40000 && o_wdt_irq !== 1'b1; n++) @(posedge i_clock);
        check("interval ok", 8'(cyc - t0 >= 32764 && cyc - t0 <= 32776), 8'h01);
        check("event irq", o_irq, 1'b1);
        t0 = cyc;
        rdc(WATCHDOG_CONTROL_OFFSET, 8'h9A, "flag set");
        wr(WATCHDOG_CONTROL_OFFSET, 8'h1A);
        check("irq no global", o_wdt_irq, 1'b0);
        wr(WATCHDOG_CONTROL_OFFSET, 8'h8A);
        check("irq no local", o_wdt_irq, 1'b0);
        wr(WATCHDOG_CONTROL_OFFSET, 8'h9A);
        check("irq both", o_wdt_irq, 1'b1);
        for (n = 0; n < 600 && o_sys_reset !== 1'b1; n++) @(posedge i_clock);
        check("reset delay ok", 8'(cyc - t0 >= 508 && cyc - t0 <= 518), 8'h01);
        for (n = 0; n < 20 && o_sys_reset === 1'b1; n++) @(posedge i_clock);
        check("reset length", 8'(n), 8'h08);
        rdc(WATCHDOG_CONTROL_OFFSET, 8'h9E, "cause flag");
        rdc(IRQ_STATUS_OFFSET, 8'h03, "event status");
        wr(IRQ_CLEAR_OFFSET, 8'h03);
        rdc(IRQ_STATUS_OFFSET, 8'h00, "status cleared");
        check("event irq cleared", o_irq, 1'b0);
        wr(WATCHDOG_CONTROL_OFFSET, 8'h01);
        rdc(WATCHDOG_CONTROL_OFFSET, 8'h00, "restart clears");
        check("irq after restart", o_wdt_irq, 1'b0);
        // Mid-run reset must bring the control and clock control registers back to their reset values
        wr(WATCHDOG_CONTROL_OFFSET, 8'h92);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        rdc(WATCHDOG_CONTROL_OFFSET, WATCHDOG_CONTROL_RESET, "control reset");
        rdc(CLOCK_CONTROL_OFFSET, CLOCK_CONTROL_RESET, "clock reset");
        finish_test();
    end
    initial
    begin
        repeat (45000) @(posedge i_clock);
        err_count++;
        finish_test();
    end
endmodule : test_system_watchdog_timer

// File: verilog/swt_divider.sv
`timescale 1ns/1ns
// Free-running divider chain; pulses once when the selected tap completes
module swt_divider
    import swt_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_restart,
    input wire logic [1:0] i_interval_sel,
    output logic o_interval_done
);
    logic [DIV_WIDTH-1:0] count_reg;
    logic [DIV_WIDTH-1:0] count_next;
    logic done_next;
    logic done_reg;

    function automatic logic [DIV_WIDTH-1:0] tap_limit(input logic [1:0] sel);
        logic [DIV_WIDTH:0] full;
        begin
            full = '0;
            case (sel)
                2'h0: full[TAP_CODE0] = 1'b1;
                2'h1: full[TAP_CODE1] = 1'b1;
                2'h2: full[TAP_CODE2] = 1'b1;
                default: full[TAP_CODE3] = 1'b1;
            endcase
            tap_limit = DIV_WIDTH'(full - 1'b1);
        end
    endfunction : tap_limit

    always_comb
    begin
        done_next = 1'b0;
        if (i_restart)
        begin
            count_next = '0;
        end
        else if (count_reg >= tap_limit(i_interval_sel))
        begin
            count_next = '0;
            done_next = 1'b1;
        end
        else
        begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            done_reg <= done_next;
        end
    end

    assign o_interval_done = done_reg;
endmodule : swt_divider

// File: verilog/swt_pkg.sv
package swt_pkg;
    // Register map on the plain software port
    localparam logic [3:0] CLOCK_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] WATCHDOG_CONTROL_OFFSET = 4'h1;
    localparam logic [3:0] IRQ_ENABLE_OFFSET = 4'h2;
    localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h3;
    localparam logic [3:0] IRQ_CLEAR_OFFSET = 4'h4;
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 8;
    // Field positions
    localparam int INTERVAL_SEL_HI_BIT = 7;
    localparam int INTERVAL_SEL_LO_BIT = 6;
    localparam int RESTART_BIT = 0;
    localparam int RESET_ENABLE_BIT = 1;
    localparam int RESET_CAUSE_BIT = 2;
    localparam int TIMEOUT_FLAG_BIT = 3;
    localparam int WDT_IRQ_ENABLE_BIT = 4;
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int EVT_TIMEOUT_BIT = 0;
    localparam int EVT_WDT_RESET_BIT = 1;
    localparam int EVT_COUNT = 2;
    // Reset values
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;
    // Divider chain taps per interval code, longer for larger codes
    localparam int DIV_WIDTH = 26;
    // Shortest tap kept small so a full time-out fits a short run
    localparam int TAP_CODE0 = 15;
    localparam int TAP_CODE1 = 20;
    localparam int TAP_CODE2 = 23;
    localparam int TAP_CODE3 = 26;
    // Timing
    localparam int RESET_DELAY_CLOCKS = 512;
    localparam int CLOCKS_PER_MACHINE_CYCLE = 4;
    localparam int RESET_HOLD_MACHINE_CYCLES = 2;
    localparam int RESET_HOLD_CLOCKS = CLOCKS_PER_MACHINE_CYCLE * RESET_HOLD_MACHINE_CYCLES;
    localparam int WAIT_WIDTH = 10;
    typedef enum logic [1:0] {SWT_COUNT, SWT_WAIT, SWT_RESET} swt_state_t;
endpackage : swt_pkg

// File: verilog/swt_watchdog.sv
`timescale 1ns/1ns
module swt_watchdog
    import swt_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [swt_pkg::ADDR_WIDTH-1:0] i_addr,
    input wire logic [swt_pkg::DATA_WIDTH-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [swt_pkg::DATA_WIDTH-1:0] o_rdata,
    output logic o_wdt_irq,
    output logic o_sys_reset,
    output logic o_irq
);
    import swt_pkg::*;

    swt_state_t state_reg;
    swt_state_t state_next;
    logic [WAIT_WIDTH-1:0] wait_reg;
    logic [WAIT_WIDTH-1:0] wait_next;
    logic [7:0] clock_control_reg;
    logic [7:0] clock_control_next;
    logic timeout_flag_reg;
    logic timeout_flag_next;
    logic reset_enable_reg;
    logic reset_enable_next;
    logic reset_cause_flag_reg;
    logic reset_cause_flag_next;
    logic wdt_irq_enable_reg;
    logic wdt_irq_enable_next;
    logic global_irq_enable_reg;
    logic global_irq_enable_next;
    logic [EVT_COUNT-1:0] evt_status_reg;
    logic [EVT_COUNT-1:0] evt_status_next;
    logic [EVT_COUNT-1:0] evt_enable_reg;
    logic [EVT_COUNT-1:0] evt_enable_next;
    logic [DATA_WIDTH-1:0] rdata_reg;
    logic [DATA_WIDTH-1:0] rdata_next;
    logic restart;
    logic interval_done;
    logic reset_fire;
    logic [EVT_COUNT-1:0] evt_pulse;

    function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr, input logic [ADDR_WIDTH-1:0] offs);
        hit = (addr == offs);
    endfunction : hit

    // Restart is a write strobe, never stored, so it always reads back zero
    assign restart = i_write && hit(i_addr, WATCHDOG_CONTROL_OFFSET) && i_wdata[RESTART_BIT];

    swt_divider u_divider
    (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_restart(restart),
        .i_interval_sel({clock_control_reg[INTERVAL_SEL_HI_BIT], clock_control_reg[INTERVAL_SEL_LO_BIT]}),
        .o_interval_done(interval_done)
    );

    // Time-out and reset state machine
    always_comb
    begin
        state_next = state_reg;
        wait_next = wait_reg;
        reset_fire = 1'b0;
        case (state_reg)
            SWT_COUNT:
            begin
                if (interval_done && !restart)
                begin
                    state_next = SWT_WAIT;
                    wait_next = '0;
                end
            end
            SWT_WAIT:
            begin
                if (restart)
                begin
                    state_next = SWT_COUNT;
                end
                else if (wait_reg == WAIT_WIDTH'(RESET_DELAY_CLOCKS - 1))
                begin
                    if (reset_enable_reg)
                    begin
                        state_next = SWT_RESET;
                        wait_next = '0;
                        reset_fire = 1'b1;
                    end
                    else
                    begin
                        state_next = SWT_COUNT;
                    end
                end
                else
                begin
                    wait_next = wait_reg + 1'b1;
                end
            end
            SWT_RESET:
            begin
                if (wait_reg == WAIT_WIDTH'(RESET_HOLD_CLOCKS - 1))
                begin
                    state_next = SWT_COUNT;
                end
                else
                begin
                    wait_next = wait_reg + 1'b1;
                end
            end
            default:
            begin
                state_next = SWT_COUNT;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= SWT_COUNT;
            wait_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            wait_reg <= wait_next;
        end
    end

    // Control and flag registers; hardware set wins over a software clear
    always_comb
    begin
        clock_control_next = clock_control_reg;
        timeout_flag_next = timeout_flag_reg;
        reset_enable_next = reset_enable_reg;
        reset_cause_flag_next = reset_cause_flag_reg;
        wdt_irq_enable_next = wdt_irq_enable_reg;
        global_irq_enable_next = global_irq_enable_reg;
        if (i_write)
        begin
            if (hit(i_addr, CLOCK_CONTROL_OFFSET))
            begin
                clock_control_next = i_wdata;
            end
            else if (hit(i_addr, WATCHDOG_CONTROL_OFFSET))
            begin
                timeout_flag_next = i_wdata[TIMEOUT_FLAG_BIT];
                reset_enable_next = i_wdata[RESET_ENABLE_BIT];
                reset_cause_flag_next = i_wdata[RESET_CAUSE_BIT];
                wdt_irq_enable_next = i_wdata[WDT_IRQ_ENABLE_BIT];
                global_irq_enable_next = i_wdata[GLOBAL_IRQ_ENABLE_BIT];
            end
        end
        if (interval_done)
        begin
            timeout_flag_next = 1'b1;
        end
        if (reset_fire)
        begin
            reset_cause_flag_next = 1'b1;
        end
    end

    // Flags survive the watchdog reset pulse: only the pin reset or a software write clears them
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            clock_control_reg <= CLOCK_CONTROL_RESET;
            timeout_flag_reg <= WATCHDOG_CONTROL_RESET[TIMEOUT_FLAG_BIT];
            reset_enable_reg <= WATCHDOG_CONTROL_RESET[RESET_ENABLE_BIT];
            reset_cause_flag_reg <= WATCHDOG_CONTROL_RESET[RESET_CAUSE_BIT];
            wdt_irq_enable_reg <= WATCHDOG_CONTROL_RESET[WDT_IRQ_ENABLE_BIT];
            global_irq_enable_reg <= WATCHDOG_CONTROL_RESET[GLOBAL_IRQ_ENABLE_BIT];
        end
        else
        begin
            clock_control_reg <= clock_control_next;
            timeout_flag_reg <= timeout_flag_next;
            reset_enable_reg <= reset_enable_next;
            reset_cause_flag_reg <= reset_cause_flag_next;
            wdt_irq_enable_reg <= wdt_irq_enable_next;
            global_irq_enable_reg <= global_irq_enable_next;
        end
    end

    // Sticky event status, enable and write-one-to-clear
    assign evt_pulse[EVT_TIMEOUT_BIT] = interval_done;
    assign evt_pulse[EVT_WDT_RESET_BIT] = reset_fire;

    always_comb
    begin
        evt_enable_next = evt_enable_reg;
        evt_status_next = evt_status_reg;
        if (i_write && hit(i_addr, IRQ_ENABLE_OFFSET))
        begin
            evt_enable_next = i_wdata[EVT_COUNT-1:0];
        end
        if (i_write && hit(i_addr, IRQ_CLEAR_OFFSET))
        begin
            evt_status_next = evt_status_next & ~i_wdata[EVT_COUNT-1:0];
        end
        evt_status_next = evt_status_next | evt_pulse;
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            evt_enable_reg <= '0;
            evt_status_reg <= '0;
        end
        else
        begin
            evt_enable_reg <= evt_enable_next;
            evt_status_reg <= evt_status_next;
        end
    end

    // Read data: one cycle after the strobe, zero otherwise and for unmapped addresses
    always_comb
    begin
        rdata_next = '0;
        if (i_read)
        begin
            if (hit(i_addr, CLOCK_CONTROL_OFFSET))
            begin
                rdata_next = clock_control_reg;
            end
            else if (hit(i_addr, WATCHDOG_CONTROL_OFFSET))
            begin
                rdata_next[TIMEOUT_FLAG_BIT] = timeout_flag_reg;
                rdata_next[RESET_ENABLE_BIT] = reset_enable_reg;
                rdata_next[RESET_CAUSE_BIT] = reset_cause_flag_reg;
                rdata_next[WDT_IRQ_ENABLE_BIT] = wdt_irq_enable_reg;
                rdata_next[GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable_reg;
            end
            else if (hit(i_addr, IRQ_ENABLE_OFFSET))
            begin
                rdata_next[EVT_COUNT-1:0] = evt_enable_reg;
            end
            else if (hit(i_addr, IRQ_STATUS_OFFSET))
            begin
                rdata_next[EVT_COUNT-1:0] = evt_status_reg;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
    // Level request while the flag stands, gated by both enables, independent of reset enable
    assign o_wdt_irq = timeout_flag_reg && wdt_irq_enable_reg && global_irq_enable_reg;
    assign o_sys_reset = (state_reg == SWT_RESET);
    assign o_irq = |(evt_status_reg & evt_enable_reg);
endmodule : swt_watchdog
